// ==== src/rsfs_consts.svh ====
`ifndef RSFS_CONSTS_SVH
`define RSFS_CONSTS_SVH
// timing counts in master clock cycles
`define FIRST_CMD_CYCLES 100
`define RST_PULSE_CYCLES 50
`define CLK_AROUND_CYCLES 10
`define POR_CYCLES 16
`define RESYNC_CYCLES 64
`define FRAME_CYCLES 256
`define TRIG_PULSE_CYCLES 4
`define CNT_W 16
`define STRAP_W 4
`endif

// ==== src/rsfs_pkg.sv ====
package rsfs_pkg;
  typedef enum logic {MODE_PROGRESSIVE, MODE_INTERLACED} out_mode_e;
  typedef enum logic {TRIG_SINGLE, TRIG_CONTINUOUS} trig_mode_e;
endpackage : rsfs_pkg

// ==== src/rsfs_if.sv ====
`timescale 1ns/1ps
interface rsfs_if;
  logic reset_n;
  logic standby;
  logic frame_sync;
  logic soft_reset_wr;
  logic ready;
  logic [3:0] gpio_in;
  logic flash_serial_in;
  logic host_frame_valid;
  logic host_frame_valid_oe_n;
  logic black_field;
  logic sensor_reset_n;
  logic sensor_trigger;
  logic sensor_trigger_oe_n;
  modport device (
    input reset_n, standby, frame_sync, soft_reset_wr, gpio_in,
    flash_serial_in,
    output ready, host_frame_valid, host_frame_valid_oe_n, black_field,
    sensor_reset_n, sensor_trigger, sensor_trigger_oe_n
  );
  modport host (
    output reset_n, standby, frame_sync, soft_reset_wr,
    input ready, host_frame_valid, host_frame_valid_oe_n, black_field
  );
endinterface : rsfs_if

// ==== src/sync2.sv ====
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sync2

// ==== src/rsfs_device.sv ====
// What this block does
// - internal power-on reset without external pulse
// - host waits 100 clocks before first command
// - hard, soft and power-on reset sources
// - serial control write starts soft reset
// - reset pin low: reset, outputs high-z
// - reset low 50 clocks, clock 10 after
// - clock runs 10 cycles before reset release
// - 100 clocks after reset release before serial
// - standby high enters, low exits hard standby
// - clock runs 10 cycles after standby high
// - clock runs 10 cycles before standby low
// - sensor reset low in reset, released on entering run
// - sample upper gpio after reset, then high-z
// - interlaced sync rise stops current frame
// - interlaced sync fall resyncs, black fields output
// - sync toggles ignored during resync period
// - progressive sync forwarded to sensor trigger
// - single-shot: one frame per trigger
// - continuous: one trigger, frames from then
// - matched cameras align frame valid within five
// - flash input strap selects host or auto config
`timescale 1ns/1ps
`include "rsfs_consts.svh"
module rsfs_device #(
  parameter int POR_CYCLES = `POR_CYCLES,
  parameter int RESYNC_CYCLES = `RESYNC_CYCLES,
  parameter int FRAME_CYCLES = `FRAME_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  rsfs_if.device lnk,
  // configuration
  input wire rsfs_pkg::out_mode_e out_mode,
  input wire rsfs_pkg::trig_mode_e trig_mode,
  // status
  output logic auto_config,
  output logic [`STRAP_W-1:0] strap,
  output logic in_standby,
  output logic streaming
);
  import rsfs_pkg::*;

  typedef enum {ST_POR, ST_RESET, ST_STRAP, ST_DEFAULT, ST_RUN}
    main_state_e;
  typedef enum {FS_IDLE, FS_STOPPED, FS_RESYNC} fs_state_e;

  ////////////////////////////////////////////////////////////////////
  logic reset_n_s;
  logic standby_s;
  logic fs_s;
  logic fs_prev_q;
  logic [`CNT_W-1:0] cnt_q;
  logic [`CNT_W-1:0] fcnt_q;
  logic [`CNT_W-1:0] rcnt_q;
  main_state_e st_q;
  fs_state_e fs_q;
  logic frame_active_q;
  logic cont_q;
  logic [1:0] trig_cnt_q;
  logic trig_q;
  logic fs_rise;
  logic fs_fall;
  logic in_reset;

  sync2 #(.W(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({lnk.reset_n, lnk.standby, lnk.frame_sync}),
    .q({reset_n_s, standby_s, fs_s})
  );

  assign fs_rise = fs_s && !fs_prev_q;
  assign fs_fall = !fs_s && fs_prev_q;
  assign in_reset = (st_q == ST_POR) || (st_q == ST_RESET);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fs_prev_q <= 1'b0;
    end else begin
      fs_prev_q <= fs_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // main reset sequence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_POR;
      cnt_q <= '0;
    end else if (!reset_n_s && st_q != ST_POR) begin
      st_q <= ST_RESET;
      cnt_q <= '0;
    end else begin
      case (st_q)
        ST_POR: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= `CNT_W'(POR_CYCLES - 1)) begin
            // pin still low: stay quiet in reset, reach strap only after release
            st_q <= reset_n_s ? ST_STRAP : ST_RESET;
          end
        end
        ST_RESET: begin
          st_q <= ST_STRAP;
        end
        ST_STRAP: begin
          st_q <= ST_DEFAULT;
        end
        ST_DEFAULT: begin
          st_q <= ST_RUN;
        end
        ST_RUN: begin
          if (lnk.soft_reset_wr) begin
            st_q <= ST_RESET;
          end
        end
        default: begin
          st_q <= ST_POR;
        end
      endcase
    end
  end

  // strap capture after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap <= '0;
      auto_config <= 1'b0;
    end else if (st_q == ST_STRAP) begin
      strap <= lnk.gpio_in;
      auto_config <= lnk.flash_serial_in;
    end
  end

  assign in_standby = standby_s && (st_q == ST_RUN);
  assign lnk.ready = (st_q == ST_RUN);
  assign lnk.sensor_reset_n = (st_q == ST_RUN);

  ////////////////////////////////////////////////////////////////////
  // interlaced frame sync
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fs_q <= FS_IDLE;
      rcnt_q <= '0;
    end else if (in_reset || out_mode != MODE_INTERLACED) begin
      fs_q <= FS_IDLE;
      rcnt_q <= '0;
    end else begin
      case (fs_q)
        FS_IDLE: begin
          if (fs_rise) begin
            fs_q <= FS_STOPPED;
          end
        end
        FS_STOPPED: begin
          if (fs_fall) begin
            fs_q <= FS_RESYNC;
            rcnt_q <= '0;
          end
        end
        FS_RESYNC: begin
          rcnt_q <= rcnt_q + 1'b1;
          if (rcnt_q >= `CNT_W'(RESYNC_CYCLES - 1)) begin
            fs_q <= FS_IDLE;
          end
        end
        default: begin
          fs_q <= FS_IDLE;
        end
      endcase
    end
  end

  assign lnk.black_field = (fs_q == FS_RESYNC);

  ////////////////////////////////////////////////////////////////////
  // progressive trigger forwarding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_q <= 1'b0;
      trig_cnt_q <= '0;
    end else if (in_reset || out_mode != MODE_PROGRESSIVE) begin
      trig_q <= 1'b0;
      trig_cnt_q <= '0;
    end else if (fs_rise && standby_s == 1'b0) begin
      trig_q <= 1'b1;
      trig_cnt_q <= 2'(`TRIG_PULSE_CYCLES - 1);
    end else if (trig_cnt_q != '0) begin
      trig_cnt_q <= trig_cnt_q - 1'b1;
    end else begin
      trig_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cont_q <= 1'b0;
    end else if (in_reset || out_mode != MODE_PROGRESSIVE ||
                 trig_mode != TRIG_CONTINUOUS) begin
      cont_q <= 1'b0;
    end else if (fs_rise) begin
      cont_q <= 1'b1;
    end
  end

  // frame timing, restarted on the synced edge for alignment
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_active_q <= 1'b0;
      fcnt_q <= '0;
    end else if (in_reset || in_standby) begin
      frame_active_q <= 1'b0;
      fcnt_q <= '0;
    end else if (out_mode == MODE_PROGRESSIVE && fs_rise) begin
      frame_active_q <= 1'b1;
      fcnt_q <= '0;
    end else if (out_mode == MODE_INTERLACED && fs_rise) begin
      frame_active_q <= 1'b0;
      fcnt_q <= '0;
    end else if (out_mode == MODE_INTERLACED && fs_q == FS_IDLE) begin
      fcnt_q <= (fcnt_q >= `CNT_W'(FRAME_CYCLES - 1)) ? '0 :
                fcnt_q + 1'b1;
      frame_active_q <= 1'b1;
    end else if (frame_active_q) begin
      if (fcnt_q >= `CNT_W'(FRAME_CYCLES - 1)) begin
        fcnt_q <= '0;
        frame_active_q <= cont_q;
      end else begin
        fcnt_q <= fcnt_q + 1'b1;
      end
    end
  end

  assign lnk.host_frame_valid = frame_active_q && fs_q == FS_IDLE;
  assign lnk.host_frame_valid_oe_n = in_reset;
  assign lnk.sensor_trigger = trig_q;
  assign lnk.sensor_trigger_oe_n = in_reset;
  assign streaming = frame_active_q;
endmodule : rsfs_device

// ==== src/rsfs_host.sv ====
`timescale 1ns/1ps
`include "rsfs_consts.svh"
module rsfs_host #(
  parameter int FIRST_CMD_CYCLES = `FIRST_CMD_CYCLES,
  parameter int RST_PULSE_CYCLES = `RST_PULSE_CYCLES,
  parameter int AROUND_CYCLES = `CLK_AROUND_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  rsfs_if.host lnk,
  // user requests
  input wire logic hard_reset_req,
  input wire logic soft_reset_req,
  input wire logic standby_req,
  input wire logic frame_sync_req,
  // status
  output logic cmd_allowed,
  output logic busy
);
  typedef enum {H_HOLD, H_WAIT, H_READY} host_state_e;

  host_state_e st_q;
  logic [`CNT_W-1:0] cnt_q;
  logic [`CNT_W-1:0] sb_cnt_q;
  logic sb_q;

  ////////////////////////////////////////////////////////////////////
  // reset pulse and command gap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= H_HOLD;
      cnt_q <= '0;
    end else begin
      case (st_q)
        H_HOLD: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= `CNT_W'(RST_PULSE_CYCLES - 1)) begin
            st_q <= H_WAIT;
            cnt_q <= '0;
          end
        end
        H_WAIT: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= `CNT_W'(FIRST_CMD_CYCLES - 1)) begin
            st_q <= H_READY;
          end
        end
        H_READY: begin
          if (hard_reset_req) begin
            st_q <= H_HOLD;
            cnt_q <= '0;
          end else if (soft_reset_req) begin
            st_q <= H_WAIT;
            cnt_q <= '0;
          end
        end
        default: begin
          st_q <= H_HOLD;
        end
      endcase
    end
  end

  assign lnk.reset_n = (st_q != H_HOLD);
  assign lnk.soft_reset_wr = (st_q == H_READY) && !hard_reset_req &&
                             soft_reset_req;
  assign cmd_allowed = (st_q == H_READY);
  assign busy = (st_q != H_READY);

  ////////////////////////////////////////////////////////////////////
  // standby level held at least the clock margin each way
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sb_q <= 1'b0;
      sb_cnt_q <= '0;
    end else if (sb_cnt_q != '0) begin
      sb_cnt_q <= sb_cnt_q - 1'b1;
    end else if (standby_req != sb_q) begin
      sb_q <= standby_req;
      sb_cnt_q <= `CNT_W'(AROUND_CYCLES);
    end
  end

  assign lnk.standby = sb_q;
  assign lnk.frame_sync = frame_sync_req;
endmodule : rsfs_host

// ==== bench/rsfs_assertions.sv ====
`timescale 1ns/1ps
module rsfs_assertions #(
  parameter int RESYNC = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic reset_n,
  input wire logic standby,
  input wire logic soft_reset_wr,
  input wire logic ready,
  input wire logic host_frame_valid,
  input wire logic host_frame_valid_oe_n,
  input wire logic black_field,
  input wire logic sensor_reset_n,
  input wire logic sensor_trigger,
  input wire logic sensor_trigger_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int unsigned blk_q;
  // length of the current black run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) blk_q <= 0;
    else blk_q <= black_field ? blk_q + 1 : 0;
  end
  //////////////////////////////
  a_por_ready_low: assert property ($fell(rst) |-> !ready[*8])
    else $error("ready too early after power on");
  a_hard_rst_hiz: assert property (!reset_n[*5] |->
    host_frame_valid_oe_n && sensor_trigger_oe_n && !ready)
    else $error("outputs driven during hard reset");
  a_sensor_rst_held: assert property (!reset_n[*5] |-> !sensor_reset_n)
    else $error("sensor reset released in reset");
  a_soft_rst_drop: assert property (soft_reset_wr && ready |=> !ready)
    else $error("soft reset did not drop ready");
  a_soft_rst_back: assert property (soft_reset_wr && ready |=> ##[1:40] ready)
    else $error("no recovery from soft reset");
  a_trig_pulse_len: assert property ($rose(sensor_trigger) |->
    sensor_trigger[*4] ##1 !sensor_trigger)
    else $error("trigger pulse length wrong");
  a_trig_driven: assert property (sensor_trigger |-> !sensor_trigger_oe_n)
    else $error("trigger high while not driven");
  a_resync_len: assert property ($fell(black_field) |-> blk_q == RESYNC)
    else $error("black run length wrong");
  a_resync_valid: assert property ($fell(black_field) |->
    ##[0:2] host_frame_valid)
    else $error("no frame after resync");
  a_frame_align: assert property ($rose(sensor_trigger) |->
    host_frame_valid)
    else $error("frame not started with trigger");
  a_standby_hold: assert property ($changed(standby) |=>
    (!$changed(standby))[*8])
    else $error("standby level changed too soon");
endmodule : rsfs_assertions

// ==== bench/tb_reset_standby_frame_sync_control.sv ====
`timescale 1ns/1ps
module tb_reset_standby_frame_sync_control;
  import rsfs_pkg::*;
  localparam int RESYNC = 32;
  localparam int FRAME = 64;
  logic clk = 0;
  logic rst = 1;
  logic hreq = 0, sreq = 0, sbreq = 0, fsreq = 0, td = 0, fd = 0;
  out_mode_e om = MODE_PROGRESSIVE;
  trig_mode_e tm = TRIG_SINGLE;
  logic [3:0] gp = 4'h0;
  logic fs = 1'b1;
  logic ac, ins, strm, ca, bz;
  logic [3:0] st;
  logic [31:0] lf = 32'h885B13E0;
  int mismatches = 0, comparisons = 0, ntr = 0, nfv = 0, nhi = 0, n;
  int cyc = 0, t0 = 0;
  int exp_q[$];
  rsfs_if lnk();
  assign lnk.gpio_in = gp;
  assign lnk.flash_serial_in = fs;
  always #12.5 clk = ~clk;
  rsfs_device #(.POR_CYCLES(8), .RESYNC_CYCLES(RESYNC), .FRAME_CYCLES(FRAME))
    rsfs_device_inst (.clk(clk), .rst(rst), .lnk(lnk), .out_mode(om),
    .trig_mode(tm), .auto_config(ac), .strap(st), .in_standby(ins),
    .streaming(strm));
  rsfs_host rsfs_host_inst (.clk(clk), .rst(rst), .lnk(lnk),
    .hard_reset_req(hreq), .soft_reset_req(sreq), .standby_req(sbreq),
    .frame_sync_req(fsreq), .cmd_allowed(ca), .busy(bz));
  rsfs_assertions #(.RESYNC(RESYNC)) rsfs_assertions_inst (.clk(clk),
    .rst(rst), .reset_n(lnk.reset_n), .standby(lnk.standby),
    .soft_reset_wr(lnk.soft_reset_wr),
    .ready(lnk.ready), .host_frame_valid(lnk.host_frame_valid),
    .host_frame_valid_oe_n(lnk.host_frame_valid_oe_n),
    .black_field(lnk.black_field), .sensor_reset_n(lnk.sensor_reset_n),
    .sensor_trigger(lnk.sensor_trigger),
    .sensor_trigger_oe_n(lnk.sensor_trigger_oe_n));
  //////////////////////////////
  always @(posedge clk) begin
    cyc++;
    td <= lnk.sensor_trigger;
    fd <= lnk.host_frame_valid;
    if (lnk.sensor_trigger && !td) ntr++;
    if (lnk.host_frame_valid && !fd) nfv++;
    if (lnk.host_frame_valid) nhi++;
  end
  function logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  task cy(int k);
    repeat (k) @(negedge clk);
  endtask : cy
  task chk(string nm, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // new strap pins, expected value queued
  task rnd;
    lf = nx(lf);
    gp = lf[3:0];
    fs = lf[4];
    exp_q.push_back({fs, gp});
  endtask : rnd
  task wready;
    for (n = 0; n < 400 && lnk.ready !== 1'b1; n++) @(negedge clk);
    chk("ready", lnk.ready, 1);
    cy(4);
    chk("strap", {ac, st}, exp_q.pop_front());
  endtask : wready
  task pulse;
    fsreq = 1;
    cy(2);
    fsreq = 0;
  endtask : pulse
  //////////////////////////////
  initial begin
    rnd();
    cy(10);
    rst = 0;
    t0 = cyc;
    chk("sensor_rst", lnk.sensor_reset_n, 0);
    wready();
    chk("sensor_rst", lnk.sensor_reset_n, 1);
    // no command before the host allows one
    for (n = 0; n < 400 && ca !== 1'b1; n++) @(negedge clk);
    chk("first_cmd", cyc - t0 >= 100 && bz === 1'b0, 1);
    $display("test power_on done");
    rnd();
    hreq = 1;
    cy(1);
    hreq = 0;
    cy(6);
    chk("hiz", {lnk.host_frame_valid_oe_n, lnk.sensor_trigger_oe_n,
      lnk.ready, lnk.sensor_reset_n}, 4'hC);
    for (n = 7; n < 300 && lnk.reset_n !== 1'b1; n++) @(negedge clk);
    chk("low_len", n >= 50 && n < 300, 1);
    for (n = 0; n < 400 && ca !== 1'b1; n++) @(negedge clk);
    chk("cmd_gap", n >= 100 && n < 400, 1);
    wready();
    $display("test hard_reset done");
    rnd();
    sreq = 1;
    cy(1);
    sreq = 0;
    for (n = 0; n < 20 && lnk.ready !== 1'b0; n++) @(negedge clk);
    chk("soft_drop", lnk.ready, 0);
    wready();
    $display("test soft_reset done");
    {ntr, nfv, nhi} = 0;
    pulse();
    cy(3 * FRAME);
    chk("trig_cnt", ntr, 1);
    chk("frame_cnt", nfv, 1);
    chk("frame_len", nhi, FRAME);
    tm = TRIG_CONTINUOUS;
    nhi = 0;
    pulse();
    cy(4 * FRAME);
    chk("cont", {nhi > 2 * FRAME, strm}, 2'h3);
    tm = TRIG_SINGLE;
    cy(3 * FRAME);
    $display("test progressive done");
    sbreq = 1;
    cy(1);
    sbreq = 0;
    cy(5);
    chk("sb_hold_high", lnk.standby, 1);
    sbreq = 1;
    cy(6);
    chk("standby", {ins, lnk.sensor_reset_n}, 2'h3);
    ntr = 0;
    pulse();
    cy(10);
    chk("trig_standby", ntr, 0);
    sbreq = 0;
    cy(1);
    sbreq = 1;
    cy(5);
    chk("sb_hold_low", lnk.standby, 0);
    sbreq = 0;
    cy(6);
    chk("standby_exit", ins, 0);
    $display("test standby done");
    om = MODE_INTERLACED;
    fsreq = 1;
    cy(6);
    chk("valid_stop", lnk.host_frame_valid, 0);
    fsreq = 0;
    cy(6);
    chk("black", lnk.black_field, 1);
    pulse();
    cy(RESYNC);
    chk("black_end", lnk.black_field, 0);
    chk("valid", lnk.host_frame_valid, 1);
    $display("test interlaced done");
    give_verdict();
  end
  // run needs about 1100 cycles
  initial begin
    repeat (20000) @(negedge clk);
    mismatches++;
    give_verdict();
  end
endmodule : tb_reset_standby_frame_sync_control
